/* File: hw/ipvs_pkg.sv */
/*
 Constants of the interrupt priority and vector select block: register
 indices, field positions, reset values and source numbering.
 Assumes an APB bus with 32-bit data, one register per aligned word.
*/
package ipvs_pkg;
   localparam int NUM_SRC = 64;
   localparam int VEC_W   = 6;
   localparam int ADDR_W  = 12;

   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_PRIO1   = 10'h001;
   localparam logic [9:0] IDX_VBASE   = 10'h007;
   localparam logic [9:0] IDX_FMATCH0 = 10'h008;
   localparam logic [9:0] IDX_FMATCH1 = 10'h009;
   localparam logic [9:0] IDX_FADDR0L = 10'h00a;
   localparam logic [9:0] IDX_FADDR0H = 10'h00b;
   localparam logic [9:0] IDX_FADDR1L = 10'h00c;
   localparam logic [9:0] IDX_FADDR1H = 10'h00d;
   localparam logic [9:0] IDX_STATUS  = 10'h00e;

   // Priority register 1 field positions
   localparam int PORTD_LSB = 14;
   localparam int FBE_LSB   = 4;
   localparam int FCC_LSB   = 2;

   // Reset values
   localparam logic [15:0] PRIO1_RST     = 16'h0000;
   localparam logic [13:0] VBASE_RST_A   = 14'h0000;
   localparam logic [13:0] VBASE_RST_B   = 14'h0080;
   localparam logic [5:0]  FMATCH_RST    = 6'h00;
   localparam logic [20:0] FADDR_RST     = 21'h000000;

   // Vector numbers of the three documented sources
   localparam logic [5:0] VEC_PORTD = 6'h20;
   localparam logic [5:0] VEC_FBE   = 6'h21;
   localparam logic [5:0] VEC_FCC   = 6'h22;

   // Level codes
   localparam logic [1:0] CODE_OFF  = 2'h0;
   localparam logic [1:0] CODE_TOP  = 2'h3;

   typedef enum logic [1:0] {
      IPVS_IDLE,
      IPVS_ACCESS
   } ipvs_bus_state_t;
endpackage

/* File: hw/ipvs_arbiter.sv */
/*
 Picks the winning ordinary request: highest level code, then lowest
 vector number. Sources with code 00 never win.
 Assumes codes are already resolved per source by the caller.
*/
`timescale 1ns/100ps
module ipvs_arbiter
   import ipvs_pkg::*;
(
   // Requests
   input  wire logic [ipvs_pkg::NUM_SRC-1:0]   req,
   input  wire logic [2*ipvs_pkg::NUM_SRC-1:0] code,
   // Result
   output logic                                found,
   output logic [ipvs_pkg::VEC_W-1:0]          win_vec,
   output logic [1:0]                          win_code
);
   always_comb begin
      found    = 1'b0;
      win_vec  = '0;
      win_code = CODE_OFF;
      // Downward scan with >= lets the lower number win a tie
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (req[i] && (code[2*i +: 2] != CODE_OFF) && (code[2*i +: 2] >= win_code)) begin
            found    = 1'b1;
            win_vec  = VEC_W'(i);
            win_code = code[2*i +: 2];
         end
      end
   end
endmodule // ipvs_arbiter

/* File: hw/ipvs_fast_select.sv */
/*
 Checks the two fast-interrupt matches against pending, enabled
 requests and picks the fast one to serve.
 Assumes software has given each fast source level 2.
*/
`timescale 1ns/100ps
module ipvs_fast_select
   import ipvs_pkg::*;
(
   // Requests
   input  wire logic [ipvs_pkg::NUM_SRC-1:0]   req,
   input  wire logic [2*ipvs_pkg::NUM_SRC-1:0] code,
   // Matches and handler addresses
   input  wire logic [ipvs_pkg::VEC_W-1:0]     match0,
   input  wire logic [ipvs_pkg::VEC_W-1:0]     match1,
   input  wire logic [20:0]                    addr0,
   input  wire logic [20:0]                    addr1,
   // Result
   output logic                                hit,
   output logic [ipvs_pkg::VEC_W-1:0]          hit_vec,
   output logic [20:0]                         hit_addr
);
   wire logic live0 = req[match0] && (code[2*match0 +: 2] != CODE_OFF);
   wire logic live1 = req[match1] && (code[2*match1 +: 2] != CODE_OFF);

   assign hit      = live0 | live1;
   assign hit_vec  = live0 ? match0 : match1;
   assign hit_addr = live0 ? addr0 : addr1;
endmodule // ipvs_fast_select

/* File: hw/ipvs_top.sv */
/*
 Interrupt priority and vector select: priority register for the port D
 and flash sources, vector base, two fast-interrupt matches, APB slave,
 and the registered vector presented to the core.
 Assumes requests and levels are synchronous to pclk; the core samples
 the vector outputs whenever irq_valid is high.
*/
`timescale 1ns/100ps
module ipvs_top
#(
   parameter bit ALT_VARIANT = 1'b0
)
(
   // Clock, reset, enable
   input  wire logic                               pclk,
   input  wire logic                               presetn,
   input  wire logic                               clk_en,
   // APB slave
   input  wire logic [ipvs_pkg::ADDR_W-1:0]        paddr,
   input  wire logic                               psel,
   input  wire logic                               penable,
   input  wire logic                               pwrite,
   input  wire logic [31:0]                        pwdata,
   output logic [31:0]                             prdata,
   output logic                                    pready,
   output logic                                    pslverr,
   // Interrupt sources
   input  wire logic [ipvs_pkg::NUM_SRC-1:0]       irq_req,
   input  wire logic [2*ipvs_pkg::NUM_SRC-1:0]     irq_src_level,
   // To the core
   output logic [20:0]                             vector_address_bus,
   output logic                                    irq_valid,
   output logic [1:0]                              irq_level,
   output logic                                    irq_fast
);
   import ipvs_pkg::*;

   localparam logic [13:0] VBASE_RST = ALT_VARIANT ? VBASE_RST_B : VBASE_RST_A;

   // Register state
   logic [15:0]       source_priority_reg_1;
   logic [13:0]       vector_base_reg;
   logic [VEC_W-1:0]  fast_irq_match_0;
   logic [VEC_W-1:0]  fast_irq_match_1_reg;
   logic [20:0]       fast_addr_0_reg;
   logic [20:0]       fast_addr_1_reg;

   // Bus state
   ipvs_bus_state_t   bus_reg;
   ipvs_bus_state_t   bus_next;
   logic [31:0]       prdata_reg;
   logic              pready_reg;
   logic              pslverr_reg;

   // Core-side outputs
   logic [20:0]       vaddr_reg;
   logic              valid_reg;
   logic [1:0]        level_reg;
   logic              fast_reg;

   // Level fields of priority register 1
   wire logic [1:0] port_d_irq_level          = source_priority_reg_1[PORTD_LSB +: 2];
   wire logic [1:0] flash_buffers_empty_level = source_priority_reg_1[FBE_LSB +: 2];
   wire logic [1:0] flash_cmd_done_level      = source_priority_reg_1[FCC_LSB +: 2];

   // Per-source level codes: documented sources from the register
   logic [2*NUM_SRC-1:0] src_code;
   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_code
         if (g == int'(VEC_PORTD)) begin : g_pd
            assign src_code[2*g +: 2] = port_d_irq_level;
         end else if (g == int'(VEC_FBE)) begin : g_fbe
            assign src_code[2*g +: 2] = flash_buffers_empty_level;
         end else if (g == int'(VEC_FCC)) begin : g_fcc
            assign src_code[2*g +: 2] = flash_cmd_done_level;
         end else begin : g_ext
            assign src_code[2*g +: 2] = irq_src_level[2*g +: 2];
         end
      end
   endgenerate

   // Arbitration
   logic              norm_found;
   logic [VEC_W-1:0]  norm_vec;
   logic [1:0]        norm_code;
   logic              fast_hit;
   logic [VEC_W-1:0]  fast_vec;
   logic [20:0]       fast_addr;

   ipvs_arbiter u_arb (
      .req      (irq_req),
      .code     (src_code),
      .found    (norm_found),
      .win_vec  (norm_vec),
      .win_code (norm_code)
   );

   ipvs_fast_select u_fast (
      .req      (irq_req),
      .code     (src_code),
      .match0   (fast_irq_match_0),
      .match1   (fast_irq_match_1_reg),
      .addr0    (fast_addr_0_reg),
      .addr1    (fast_addr_1_reg),
      .hit      (fast_hit),
      .hit_vec  (fast_vec),
      .hit_addr (fast_addr)
   );

   // Fast request pre-empts the whole ordinary arbitration
   wire logic        any_req   = fast_hit | norm_found;
   wire logic [20:0] table_vaddr = {vector_base_reg, norm_vec, 1'b0};
   wire logic [20:0] vaddr_next  = fast_hit ? fast_addr : table_vaddr;
   wire logic [1:0]  lvl_next  = fast_hit ? 2'h2 : (norm_code - 2'h1);
   wire logic [VEC_W-1:0] cur_vec = fast_hit ? fast_vec : norm_vec;

   // Address decode
   wire logic [9:0] idx      = paddr[ADDR_W-1:2];
   wire logic       setup    = psel & ~penable;
   wire logic       wr_go    = psel & penable & pwrite & pready_reg;
   wire logic       hit_pr1  = (idx == IDX_PRIO1);
   wire logic       hit_vb   = (idx == IDX_VBASE);
   wire logic       hit_fm0  = (idx == IDX_FMATCH0);
   wire logic       hit_fm1  = (idx == IDX_FMATCH1);
   wire logic       hit_f0l  = (idx == IDX_FADDR0L);
   wire logic       hit_f0h  = (idx == IDX_FADDR0H);
   wire logic       hit_f1l  = (idx == IDX_FADDR1L);
   wire logic       hit_f1h  = (idx == IDX_FADDR1H);
   wire logic       hit_st   = (idx == IDX_STATUS);
   wire logic       mapped   = hit_pr1 | hit_vb | hit_fm0 | hit_fm1 | hit_f0l | hit_f0h
                               | hit_f1l | hit_f1h | hit_st;
   wire logic       wr_ok    = wr_go & (paddr[1:0] == 2'b00);
   wire logic       bad_acc  = ~mapped | (paddr[1:0] != 2'b00) | (pwrite & hit_st);
   wire logic       answer   = setup & (bus_reg == IPVS_IDLE);

   // Per-register write strobes
   wire logic       wr_pr1   = wr_ok & hit_pr1;
   wire logic       wr_vb    = wr_ok & hit_vb;
   wire logic       wr_fm0   = wr_ok & hit_fm0;
   wire logic       wr_fm1   = wr_ok & hit_fm1;
   wire logic       wr_f0l   = wr_ok & hit_f0l;
   wire logic       wr_f0h   = wr_ok & hit_f0h;
   wire logic       wr_f1l   = wr_ok & hit_f1l;
   wire logic       wr_f1h   = wr_ok & hit_f1h;

   // Read mux; reserved bits read zero
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_pr1) begin
         rd_mux[15:0] = source_priority_reg_1 & 16'hc03c;
      end else if (hit_vb) begin
         rd_mux[13:0] = vector_base_reg;
      end else if (hit_fm0) begin
         rd_mux[5:0] = fast_irq_match_0;
      end else if (hit_fm1) begin
         rd_mux[5:0] = fast_irq_match_1_reg;
      end else if (hit_f0l) begin
         rd_mux[15:0] = fast_addr_0_reg[15:0];
      end else if (hit_f0h) begin
         rd_mux[4:0] = fast_addr_0_reg[20:16];
      end else if (hit_f1l) begin
         rd_mux[15:0] = fast_addr_1_reg[15:0];
      end else if (hit_f1h) begin
         rd_mux[4:0] = fast_addr_1_reg[20:16];
      end else if (hit_st) begin
         rd_mux[10:0] = {fast_reg, valid_reg, level_reg, cur_vec, 1'b0};
      end
   end

   // Bus sequencer: no wait state, answer in the first access cycle
   always_comb begin
      bus_next = bus_reg;
      case (bus_reg)
         IPVS_IDLE:   if (setup) bus_next = IPVS_ACCESS;
         IPVS_ACCESS: if (psel & penable & pready_reg) bus_next = IPVS_IDLE;
         default:     bus_next = IPVS_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_reg <= IPVS_IDLE;
      end else if (clk_en) begin
         bus_reg <= bus_next;
      end
   end

   // One-cycle answer, error flag alongside it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else if (clk_en) begin
         pready_reg  <= answer;
         pslverr_reg <= answer & bad_acc;
      end
   end

   // Read data taken at the setup edge so it stands with pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (clk_en && setup && !pwrite) begin
         prdata_reg <= rd_mux;
      end
   end

   // Registers steered by software, one short process each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         source_priority_reg_1 <= PRIO1_RST;
      end else if (clk_en && wr_pr1) begin
         // Reserved bits are dropped so they always read zero
         source_priority_reg_1 <= pwdata[15:0] & 16'hc03c;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector_base_reg <= VBASE_RST;
      end else if (clk_en && wr_vb) begin
         vector_base_reg <= pwdata[13:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_irq_match_0 <= FMATCH_RST;
      end else if (clk_en && wr_fm0) begin
         fast_irq_match_0 <= pwdata[5:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_irq_match_1_reg <= FMATCH_RST;
      end else if (clk_en && wr_fm1) begin
         fast_irq_match_1_reg <= pwdata[5:0];
      end
   end

   // Each half of a handler address lands on its own write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_addr_0_reg <= FADDR_RST;
      end else if (clk_en) begin
         if (wr_f0l) begin
            fast_addr_0_reg[15:0] <= pwdata[15:0];
         end else if (wr_f0h) begin
            fast_addr_0_reg[20:16] <= pwdata[4:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_addr_1_reg <= FADDR_RST;
      end else if (clk_en) begin
         if (wr_f1l) begin
            fast_addr_1_reg[15:0] <= pwdata[15:0];
         end else if (wr_f1h) begin
            fast_addr_1_reg[20:16] <= pwdata[4:0];
         end
      end
   end

   // Vector presented to the core, registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid_reg <= 1'b0;
         fast_reg  <= 1'b0;
      end else if (clk_en) begin
         valid_reg <= any_req;
         fast_reg  <= fast_hit;
      end
   end

   // Address and level keep their last value while nothing is pending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vaddr_reg <= 21'h000000;
         level_reg <= 2'h0;
      end else if (clk_en && any_req) begin
         vaddr_reg <= vaddr_next;
         level_reg <= lvl_next;
      end
   end

   assign prdata             = prdata_reg;
   assign pready             = pready_reg;
   assign pslverr            = pslverr_reg;
   assign vector_address_bus = vaddr_reg;
   assign irq_valid          = valid_reg;
   assign irq_level          = level_reg;
   assign irq_fast           = fast_reg;
endmodule // ipvs_top

/* File: verif/ipvs_properties.sv */
/*
 Port-level checker for the priority and vector select block.
 Bound into ipvs_top; sees only its ports.
*/
`timescale 1ns/100ps
module ipvs_checker
   import ipvs_pkg::*;
#(
   parameter bit ALT_VARIANT = 1'b0
)
(
   // Clock, reset, enable
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   clk_en,
   // APB
   input wire logic [ADDR_W-1:0]      paddr,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [31:0]            pwdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   // Sources and core side
   input wire logic [NUM_SRC-1:0]     irq_req,
   input wire logic [2*NUM_SRC-1:0]   irq_src_level,
   input wire logic [20:0]            vector_address_bus,
   input wire logic                   irq_valid,
   input wire logic [1:0]             irq_level,
   input wire logic                   irq_fast
);
   logic [13:0] base_q;
   wire         wr_base = clk_en && psel && penable && pready && pwrite && !pslverr
                          && paddr == {IDX_VBASE, 2'h0};

   // Shadow of the vector base, to check the upper address bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         base_q <= ALT_VARIANT ? VBASE_RST_B : VBASE_RST_A;
      else if (wr_base)
         base_q <= pwdata[13:0];
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_setup_answer: assert property (psel && !penable && clk_en |=> pready)
      else $error("pready not in first access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_level_cap: assert property (irq_valid |-> irq_level != 2'h3)
      else $error("level above two");
   a_fast_top: assert property (irq_fast |-> irq_valid && irq_level == 2'h2)
      else $error("fast request not at level two");
   a_idle_quiet: assert property (clk_en && irq_req == '0 |=> !irq_valid)
      else $error("valid without request");
   a_enabled_seen: assert property (clk_en && irq_req[5]
      && irq_src_level[11:10] != 2'h0 |=> irq_valid)
      else $error("enabled request not presented");
   a_vector_base: assert property (irq_valid && !irq_fast
      |-> vector_address_bus[20:7] == $past(base_q) && !vector_address_bus[0])
      else $error("vector address not built on base");
   a_vector_hold: assert property (irq_valid ##1 !irq_valid |-> $stable(vector_address_bus))
      else $error("vector address moved when valid fell");

   c_fast: cover property (irq_fast);
   c_err: cover property (pslverr);
   c_top: cover property (irq_valid && !irq_fast && irq_level == 2'h2);
endmodule // ipvs_checker

bind ipvs_top ipvs_checker #(.ALT_VARIANT(ALT_VARIANT)) u_chk (
   .pclk, .presetn, .clk_en, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
   .pslverr, .irq_req, .irq_src_level, .vector_address_bus, .irq_valid, .irq_level,
   .irq_fast);

/* File: verif/ipvs_core_model.sv */
/*
 Core-side model: takes the vector, level and kind on every edge
 at which a request is presented. Assumes one clock with the block.
*/
`timescale 1ns/100ps
module ipvs_core_model (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // From the controller
   input  wire logic [20:0] vector_address_bus,
   input  wire logic        irq_valid,
   input  wire logic [1:0]  irq_level,
   input  wire logic        irq_fast,
   // Last vector taken
   output logic [20:0]      took_addr,
   output logic [1:0]       took_level,
   output logic             took_fast
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         took_addr <= 21'h000000;
         took_level <= 2'h0;
         took_fast <= 1'h0;
      end else if (irq_valid) begin
         // A fast request carries the handler address itself, no table step
         took_addr <= vector_address_bus;
         took_level <= irq_level;
         took_fast <= irq_fast;
      end
   end
endmodule // ipvs_core_model

/* File: verif/irq_priority_vector_select_test.sv */
/*
 Self-checking bench: APB register access and random request arbitration.
 Assumes ipvs_top built with the alternate reset variant.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin \
   tests_run++; \
   if ((g) !== (e)) begin \
      err_total++; \
      $display("wrong value %s expected %h seen %h", n, e, g); \
   end \
end
module irq_priority_vector_select_test;
   import ipvs_pkg::*;
   logic                 pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, er;
   logic                 irq_valid, irq_fast, took_fast;
   logic [ADDR_W-1:0]    paddr;
   logic [31:0]          pwdata, prdata, rd;
   logic [NUM_SRC-1:0]   irq_req, req_v;
   logic [2*NUM_SRC-1:0] irq_src_level, lvl_v;
   logic [20:0]          vector_address_bus, took_addr, fa0, fa1;
   logic [1:0]           irq_level, took_level;
   logic [15:0]          prio;
   logic [13:0]          vb;
   logic [5:0]           m0, m1;
   logic [24:0]          exp;
   int                   err_total, tests_run, seed;

   ipvs_top #(.ALT_VARIANT(1'b1)) uut (.pclk, .presetn, .clk_en, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq_req, .irq_src_level,
      .vector_address_bus, .irq_valid, .irq_level, .irq_fast);
   ipvs_core_model core (.pclk, .presetn, .vector_address_bus, .irq_valid, .irq_level,
      .irq_fast, .took_addr, .took_level, .took_fast);

   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end

   task automatic end_of_test();
      if (err_total == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      end_of_test();
   end

   // One APB transfer; waits for pready at a rising edge, only the watchdog ends a hang
   task automatic apb(input logic w, input logic [9:0] ix, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {ix, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do
         @(posedge pclk);
      while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   function automatic logic [1:0] code_of(input int i);
      if (i == VEC_PORTD) return prio[15:14];
      if (i == VEC_FBE) return prio[5:4];
      if (i == VEC_FCC) return prio[3:2];
      return lvl_v[2*i +: 2];
   endfunction

   // Expected {valid, fast, level, vector address}
   function automatic logic [24:0] predict();
      int b;
      b = -1;
      for (int i = 0; i < NUM_SRC; i++)
         if (req_v[i] && code_of(i) != CODE_OFF && (b < 0 || code_of(i) > code_of(b)))
            b = i;
      if (req_v[m0] && code_of(m0) != CODE_OFF) return {2'h3, 2'h2, fa0};
      if (req_v[m1] && code_of(m1) != CODE_OFF) return {2'h3, 2'h2, fa1};
      if (b < 0) return 25'h0;
      return {2'h2, code_of(b) - 2'h1, vb, 6'(b), 1'h0};
   endfunction

   initial begin
      seed = 81;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      clk_en = 1'h1;
      irq_req = '0;
      irq_src_level = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, IDX_PRIO1, 32'h0);
      `CHK("prio reset", 32'h0, rd)
      apb(1'h0, IDX_VBASE, 32'h0);
      `CHK("base reset", 32'h80, rd)
      apb(1'h0, IDX_FMATCH0, 32'h0);
      `CHK("match reset", 32'h0, rd)
      apb(1'h0, 10'h3fc, 32'h0);
      `CHK("unmapped", 33'h100000000, {er, rd})
      apb(1'h1, IDX_STATUS, 32'h0);
      `CHK("status write", 1'h1, er)
      apb(1'h1, IDX_VBASE, $random(seed));
      vb = pwdata[13:0];
      apb(1'h0, IDX_VBASE, 32'h0);
      `CHK("base", {18'h0, vb}, rd)
      fa0 = 21'($random(seed));
      fa1 = 21'($random(seed));
      apb(1'h1, IDX_FADDR0L, {16'h0, fa0[15:0]});
      apb(1'h1, IDX_FADDR0H, {27'h0, fa0[20:16]});
      apb(1'h1, IDX_FADDR1L, {16'h0, fa1[15:0]});
      apb(1'h1, IDX_FADDR1H, {27'h0, fa1[20:16]});
      for (int t = 0; t < 40; t++) begin
         apb(1'h1, IDX_PRIO1, $random(seed));
         prio = pwdata[15:0] & 16'hc03c;
         apb(1'h0, IDX_PRIO1, 32'h0);
         `CHK("prio", {16'h0, prio}, rd)
         apb(1'h1, IDX_FMATCH0, $random(seed) | 32'h4);
         m0 = pwdata[5:0];
         apb(1'h0, IDX_FMATCH0, 32'h0);
         `CHK("match", {26'h0, m0}, rd)
         apb(1'h1, IDX_FMATCH1, $random(seed) | 32'h4);
         m1 = pwdata[5:0];
         req_v = {$random(seed), $random(seed)} & {$random(seed), $random(seed)};
         req_v = (t == 0) ? '0 : (t == 1) ? '1 : req_v;
         lvl_v = {$random(seed), $random(seed), $random(seed), $random(seed)};
         lvl_v[2*m0 +: 2] = 2'h3;
         lvl_v[2*m1 +: 2] = 2'h3;
         irq_req <= req_v;
         irq_src_level <= lvl_v;
         exp = predict();
         repeat (2) @(posedge pclk);
         @(negedge pclk);
         `CHK("valid", exp[24], irq_valid)
         if (exp[24]) begin
            `CHK("fast", exp[23], took_fast)
            `CHK("level", exp[22:21], took_level)
            `CHK("vector", exp[20:0], took_addr)
            apb(1'h0, IDX_STATUS, 32'h0);
            `CHK("status", {exp[23], exp[24], exp[22:21]}, rd[10:7])
         end
      end
      end_of_test();
   end
endmodule // irq_priority_vector_select_test
